// File: logic/usp_pkg.sv
package usp_pkg;

   // ---------------------------------------------------------------
   // Register offsets, decoded from the three select lines.
   // ---------------------------------------------------------------
   localparam logic [2:0] OFF_DATA  = 3'h0;   // Receive/transmit buffer, or divisor low byte.
   localparam logic [2:0] OFF_IEN   = 3'h1;   // Interrupt enables, or divisor high byte.
   localparam logic [2:0] OFF_IID   = 3'h2;
   localparam logic [2:0] OFF_LCTL  = 3'h3;
   localparam logic [2:0] OFF_MCTL  = 3'h4;
   localparam logic [2:0] OFF_LSTAT = 3'h5;
   localparam logic [2:0] OFF_MSTAT = 3'h6;

   // ---------------------------------------------------------------
   // Field positions.
   // ---------------------------------------------------------------
   localparam int LC_PAR_EN  = 3;   // Line control: parity enable.
   localparam int LC_PAR_EVN = 4;   // Line control: even parity select.
   localparam int LC_DAB     = 7;   // Line control: divisor access bit.
   localparam int MC_LOOP    = 4;   // Modem control: diagnostic loop.
   localparam int IE_RXD     = 0;
   localparam int IE_THRE    = 1;
   localparam int IE_LINE    = 2;
   localparam int IE_MODEM   = 3;

   // ---------------------------------------------------------------
   // Reset values and identification codes.
   // ---------------------------------------------------------------
   localparam logic [7:0] IID_RESET = 8'h01;
   localparam logic [7:0] ZERO8     = 8'h00;
   localparam logic [1:0] CODE_LINE = 2'h3;
   localparam logic [1:0] CODE_RXD  = 2'h2;
   localparam logic [1:0] CODE_THRE = 2'h1;
   localparam logic [1:0] CODE_MDM  = 2'h0;

   // One-hot pending vector: bit order by source.
   typedef enum logic [3:0] {
      SRC_LINE  = 4'b0001,
      SRC_RXD   = 4'b0010,
      SRC_THRE  = 4'b0100,
      SRC_MODEM = 4'b1000
   } usp_src_t;

   // Host port pins, all synchronous to the system clock.
   typedef struct packed {
      logic       chip_sel_hi_a;
      logic       chip_sel_hi_b;
      logic       chip_sel_lo_n;
      logic       sel_latch_n;
      logic [2:0] reg_sel;
      logic       rd_strobe_hi;
      logic       rd_strobe_n;
      logic       wr_strobe_hi;
      logic       wr_strobe_n;
   } usp_bus_t;

   // One received character from the serial shifter.
   typedef struct packed {
      logic       valid;
      logic [7:0] data;
      logic       par_bit;
      logic       frame_err;
      logic       brk;
   } usp_rx_t;

   // Active-low modem inputs.
   typedef struct packed {
      logic cts_n;
      logic dsr_n;
      logic bell_in_n;
      logic carrier_detect_n;
   } usp_modem_in_t;

endpackage : usp_pkg

// File: logic/usp_host_latch.sv
`timescale 1ns/1ps
module usp_host_latch (
   input  wire logic              i_sys_clk,
   input  wire logic              i_resetn,
   input  wire logic              i_clk_en,
   input  wire usp_pkg::usp_bus_t i_bus,
   output logic                   o_sel,
   output logic [2:0]             o_addr,
   output logic                   o_rd_act,
   output logic                   o_wr_act,
   output logic                   o_rd_go,
   output logic                   o_wr_go
);

   logic       sel_r;
   logic [2:0] addr_r;
   logic       rd_prev_r;
   logic       wr_prev_r;
   logic       rd_lvl;
   logic       wr_lvl;

   // ---------------------------------------------------------------
   // Select capture.
   // ---------------------------------------------------------------
   // Decode and select lines follow the pins while the latch strobe is low
   // and hold once it rises; a host with stable lines ties it low.
   always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         sel_r  <= 1'b0;
         addr_r <= 3'h0;
      end else if (i_clk_en && !i_bus.sel_latch_n) begin
         sel_r  <= i_bus.chip_sel_hi_a && i_bus.chip_sel_hi_b && !i_bus.chip_sel_lo_n;
         addr_r <= i_bus.reg_sel;
      end
   end

   // Either strobe polarity counts; the unused one is tied inactive.
   assign rd_lvl = sel_r && (i_bus.rd_strobe_hi || !i_bus.rd_strobe_n);
   assign wr_lvl = sel_r && (i_bus.wr_strobe_hi || !i_bus.wr_strobe_n);

   // Previous strobe levels, so side effects fire once per access.
   always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         rd_prev_r <= 1'b0;
         wr_prev_r <= 1'b0;
      end else if (i_clk_en) begin
         rd_prev_r <= rd_lvl;
         wr_prev_r <= wr_lvl;
      end
   end

   assign o_sel    = sel_r;
   assign o_addr   = addr_r;
   assign o_rd_act = rd_lvl;
   assign o_wr_act = wr_lvl;
   assign o_rd_go  = rd_lvl && !rd_prev_r;
   assign o_wr_go  = wr_lvl && !wr_prev_r;

endmodule : usp_host_latch

// File: logic/usp_irq_prio.sv
`timescale 1ns/1ps
module usp_irq_prio (
   input  wire logic [3:0] i_pend,
   output logic [1:0]      o_code,
   output logic            o_none
);

   // ---------------------------------------------------------------
   // Fixed priority encoder.
   // ---------------------------------------------------------------
   // Line status beats received data, which beats transmit empty,
   // which beats modem status.
   always_comb begin
      o_none = 1'b0;
      if (i_pend[0]) begin
         o_code = usp_pkg::CODE_LINE;
      end else if (i_pend[1]) begin
         o_code = usp_pkg::CODE_RXD;
      end else if (i_pend[2]) begin
         o_code = usp_pkg::CODE_THRE;
      end else if (i_pend[3]) begin
         o_code = usp_pkg::CODE_MDM;
      end else begin
         o_code = usp_pkg::CODE_MDM;
         o_none = 1'b1;
      end
   end

endmodule : usp_irq_prio

// File: logic/usp_core.sv
// Functional notes
// - Data ready sets on character, clears read/write0.
// - Overrun sets on unread buffer overwrite.
// - Parity error sets on bad parity.
// - Priority: line, data, transmit, modem.
// - Identification read freezes reported code.
// - Identification bit 0 high when idle.
// - Bits 1-2 name highest pending source.
// - Identification bits 3-7 read zero.
// - One enable bit per interrupt source.
// - Enable bits 4-7 read zero.
// - No enables: output low, status still updates.
// - Loop mode takes modem sources from control.
// - Writing modem status low bits raises interrupts.
// - Status bit 6 is inverse ring input.
// - Status bit 7 is inverse carrier input.
// - Carrier change flag sets and interrupts.
// - Ring trailing edge flag sets and interrupts.
// - Select needs both high selects, low select.
// - Either strobe polarity reads or writes.
// - Select lines latched while strobe low.
// - Divisor access bit steers target register.
// - Modem outputs active low, high on reset.
// - Each interrupt cleared by its own access.
// - Reset: idle code, enables and control cleared.
// - Offsets 0 to 6 decode the registers.
`timescale 1ns/1ps
module usp_core (
   input  wire logic                   i_sys_clk,
   input  wire logic                   i_resetn,
   input  wire logic                   i_clk_en,
   input  wire usp_pkg::usp_bus_t      i_bus,
   input  wire logic [7:0]             i_data,
   output logic [7:0]                  o_data,
   output logic                        o_data_oe,
   input  wire usp_pkg::usp_rx_t       i_rx,
   input  wire logic                   i_tx_taken,
   input  wire logic                   i_tx_idle,
   output logic [7:0]                  o_tx_data,
   output logic                        o_tx_load,
   output logic [15:0]                 o_divisor,
   output logic [7:0]                  o_line_ctl,
   input  wire usp_pkg::usp_modem_in_t i_modem,
   output logic                        o_irq_out,
   output logic                        o_term_ready_n,
   output logic                        o_send_req_n,
   output logic                        o_user_out1_n,
   output logic                        o_user_out2_n
);

   // ---------------------------------------------------------------
   // Declarations.
   // ---------------------------------------------------------------
   logic       sel;
   logic [2:0] addr;
   logic       rd_act;
   logic       wr_act;
   logic       rd_go;
   logic       wr_go;
   logic [7:0] ier_r;
   logic [7:0] mcr_r;
   logic [7:0] lcr_r;
   logic [7:0] dll_r;
   logic [7:0] dlm_r;
   logic [7:0] rbr_r;
   logic [7:0] thr_r;
   logic       tx_load_r;
   logic       dr_r;
   logic       oe_r;
   logic       pe_r;
   logic       fe_r;
   logic       bi_r;
   logic       thre_r;
   logic       thre_pend_r;
   logic [3:0] mdelta_r;
   logic [3:0] mlvl_prev_r;
   logic [3:0] mlvl;
   logic [7:0] line_state_flags;
   logic [7:0] modem_input_state;
   logic [3:0] pend;
   logic [1:0] code;
   logic       none;
   logic       freeze;
   logic [7:0] iir_r;
   logic [7:0] iir_nxt;
   logic [7:0] rd_mux;
   logic       dab;
   logic       par_bad;
   logic       irq_r;
   logic [7:0] dout_r;
   logic       doe_r;
   logic [3:0] mout_n_r;

   // True when this access strobe targets the given offset.
   function automatic logic hit(input logic go, input logic [2:0] a, input logic [2:0] off);
      hit = go && (a == off);
   endfunction : hit

   // ---------------------------------------------------------------
   // Host port.
   // ---------------------------------------------------------------
   usp_host_latch u_latch (
      .i_sys_clk (i_sys_clk),
      .i_resetn  (i_resetn),
      .i_clk_en  (i_clk_en),
      .i_bus     (i_bus),
      .o_sel     (sel),
      .o_addr    (addr),
      .o_rd_act  (rd_act),
      .o_wr_act  (wr_act),
      .o_rd_go   (rd_go),
      .o_wr_go   (wr_go)
   );

   assign dab = lcr_r[usp_pkg::LC_DAB];

   // ---------------------------------------------------------------
   // Writable control registers.
   // ---------------------------------------------------------------
   // Writes land on the first cycle of the strobe only, so a long strobe
   // cannot load the transmitter twice.
   always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         ier_r     <= usp_pkg::ZERO8;
         mcr_r     <= usp_pkg::ZERO8;
         lcr_r     <= usp_pkg::ZERO8;
         dll_r     <= usp_pkg::ZERO8;
         dlm_r     <= usp_pkg::ZERO8;
         thr_r     <= usp_pkg::ZERO8;
         tx_load_r <= 1'b0;
      end else if (i_clk_en) begin
         tx_load_r <= 1'b0;
         if (hit(wr_go, addr, usp_pkg::OFF_DATA)) begin
            if (dab) begin
               dll_r <= i_data;
            end else begin
               thr_r     <= i_data;
               tx_load_r <= 1'b1;
            end
         end else if (hit(wr_go, addr, usp_pkg::OFF_IEN)) begin
            if (dab) begin
               dlm_r <= i_data;
            end else begin
               ier_r <= {4'h0, i_data[3:0]};
            end
         end else if (hit(wr_go, addr, usp_pkg::OFF_LCTL)) begin
            lcr_r <= i_data;
         end else if (hit(wr_go, addr, usp_pkg::OFF_MCTL)) begin
            mcr_r <= {3'h0, i_data[4:0]};
         end
      end
   end

   // ---------------------------------------------------------------
   // Line status flags.
   // ---------------------------------------------------------------
   // Parity is checked only when enabled; even select picks the sense.
   assign par_bad = lcr_r[usp_pkg::LC_PAR_EN] &&
                    ((^{i_rx.data, i_rx.par_bit}) == lcr_r[usp_pkg::LC_PAR_EVN]);

   // Clears are written first so that a same-cycle event wins.
   always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         dr_r  <= 1'b0;
         oe_r  <= 1'b0;
         pe_r  <= 1'b0;
         fe_r  <= 1'b0;
         bi_r  <= 1'b0;
         rbr_r <= usp_pkg::ZERO8;
      end else if (i_clk_en) begin
         if (hit(rd_go, addr, usp_pkg::OFF_DATA) && !dab) begin
            dr_r <= 1'b0;
         end
         if (hit(wr_go, addr, usp_pkg::OFF_LSTAT) && !i_data[0]) begin
            dr_r <= 1'b0;
         end
         if (hit(rd_go, addr, usp_pkg::OFF_LSTAT)) begin
            oe_r <= 1'b0;
            pe_r <= 1'b0;
            fe_r <= 1'b0;
            bi_r <= 1'b0;
         end
         if (i_rx.valid) begin
            rbr_r <= i_rx.data;
            dr_r  <= 1'b1;
            // A read in the same cycle took the old character first.
            if (dr_r && !(hit(rd_go, addr, usp_pkg::OFF_DATA) && !dab)) begin
               oe_r <= 1'b1;
            end
            if (par_bad) begin
               pe_r <= 1'b1;
            end
            if (i_rx.frame_err) begin
               fe_r <= 1'b1;
            end
            if (i_rx.brk) begin
               bi_r <= 1'b1;
            end
         end
      end
   end

   // Transmit holding empty, and its interrupt which clears separately.
   always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         thre_r      <= 1'b1;
         thre_pend_r <= 1'b0;
      end else if (i_clk_en) begin
         if (tx_load_r) begin
            thre_r      <= 1'b0;
            thre_pend_r <= 1'b0;
         end
         if (rd_go && addr == usp_pkg::OFF_IID && iir_r[2:0] == {usp_pkg::CODE_THRE, 1'b0}) begin
            thre_pend_r <= 1'b0;
         end
         if (i_tx_taken) begin
            thre_r      <= 1'b1;
            thre_pend_r <= 1'b1;
         end
      end
   end

   assign line_state_flags = {1'b0, i_tx_idle, thre_r, bi_r, fe_r, pe_r, oe_r, dr_r};

   // ---------------------------------------------------------------
   // Modem status.
   // ---------------------------------------------------------------
   // Levels in order cts, dsr, bell, carrier; loop mode feeds them from
   // the control register and ignores the input pins; the modem outputs still follow control bits 0 to 3.
   always_comb begin
      if (mcr_r[usp_pkg::MC_LOOP]) begin
         mlvl = {mcr_r[1], mcr_r[0], mcr_r[2], mcr_r[3]};
      end else begin
         mlvl = ~{i_modem.cts_n, i_modem.dsr_n, i_modem.bell_in_n, i_modem.carrier_detect_n};
      end
   end

   // Delta bits: 0 cts change, 1 dsr change, 2 bell trailing, 3 carrier.
   always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         mdelta_r    <= 4'h0;
         mlvl_prev_r <= 4'h0;
      end else if (i_clk_en) begin
         mlvl_prev_r <= mlvl;
         if (hit(rd_go, addr, usp_pkg::OFF_MSTAT)) begin
            mdelta_r <= 4'h0;
         end
         if (hit(wr_go, addr, usp_pkg::OFF_MSTAT)) begin
            mdelta_r <= mdelta_r | i_data[3:0];
         end
         if (mlvl[3] != mlvl_prev_r[3]) begin
            mdelta_r[0] <= 1'b1;
         end
         if (mlvl[2] != mlvl_prev_r[2]) begin
            mdelta_r[1] <= 1'b1;
         end
         if (!mlvl[1] && mlvl_prev_r[1]) begin
            mdelta_r[2] <= 1'b1;
         end
         if (mlvl[0] != mlvl_prev_r[0]) begin
            mdelta_r[3] <= 1'b1;
         end
      end
   end

   assign modem_input_state = {mlvl[0], mlvl[1], mlvl[2], mlvl[3], mdelta_r};

   // ---------------------------------------------------------------
   // Interrupt identification.
   // ---------------------------------------------------------------
   // Status above keeps updating even with every enable off.
   assign pend = {(|mdelta_r) && ier_r[usp_pkg::IE_MODEM],
                  thre_pend_r && ier_r[usp_pkg::IE_THRE],
                  dr_r && ier_r[usp_pkg::IE_RXD],
                  (oe_r || pe_r || fe_r || bi_r) && ier_r[usp_pkg::IE_LINE]};

   usp_irq_prio u_prio (
      .i_pend (pend),
      .o_code (code),
      .o_none (none)
   );

   assign freeze  = rd_act && addr == usp_pkg::OFF_IID;
   assign iir_nxt = {5'h00, code, none};

   // The code is held for the whole read so the host services what it saw.
   always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         iir_r <= usp_pkg::IID_RESET;
         irq_r <= 1'b0;
      end else if (i_clk_en) begin
         if (!freeze) begin
            iir_r <= iir_nxt;
         end
         irq_r <= !none;
      end
   end

   // ---------------------------------------------------------------
   // Read data and pins.
   // ---------------------------------------------------------------
   always_comb begin
      if (addr == usp_pkg::OFF_DATA) begin
         rd_mux = dab ? dll_r : rbr_r;
      end else if (addr == usp_pkg::OFF_IEN) begin
         rd_mux = dab ? dlm_r : ier_r;
      end else if (addr == usp_pkg::OFF_IID) begin
         rd_mux = iir_r;
      end else if (addr == usp_pkg::OFF_LCTL) begin
         rd_mux = lcr_r;
      end else if (addr == usp_pkg::OFF_MCTL) begin
         rd_mux = mcr_r;
      end else if (addr == usp_pkg::OFF_LSTAT) begin
         rd_mux = line_state_flags;
      end else if (addr == usp_pkg::OFF_MSTAT) begin
         rd_mux = modem_input_state;
      end else begin
         rd_mux = usp_pkg::ZERO8;
      end
   end

   // Bus driven one cycle after the strobe is seen, for as long as it lasts.
   always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         dout_r <= usp_pkg::ZERO8;
         doe_r  <= 1'b0;
      end else if (i_clk_en) begin
         doe_r <= rd_act;
         if (rd_act) begin
            dout_r <= rd_mux;
         end
      end
   end

   // Modem outputs are inverted copies of control bits 0 to 3.
   always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         mout_n_r <= 4'hF;
      end else if (i_clk_en) begin
         mout_n_r <= ~mcr_r[3:0];
      end
   end

   assign o_data         = dout_r;
   assign o_data_oe      = doe_r;
   assign o_tx_data      = thr_r;
   assign o_tx_load      = tx_load_r;
   assign o_divisor      = {dlm_r, dll_r};
   assign o_line_ctl     = lcr_r;
   assign o_irq_out      = irq_r;
   assign o_term_ready_n = mout_n_r[0];
   assign o_send_req_n   = mout_n_r[1];
   assign o_user_out1_n  = mout_n_r[2];
   assign o_user_out2_n  = mout_n_r[3];

   // ---------------------------------------------------------------
   // Checks.
   // ---------------------------------------------------------------
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_resetn);

   sequence lsr_read_s;
      i_clk_en && rd_go && addr == usp_pkg::OFF_LSTAT;
   endsequence

   sequence iid_hold_s;
      i_clk_en && freeze;
   endsequence

   rx_ready_set_a: assert property (i_clk_en && i_rx.valid |=> dr_r)
      else $error("data ready not set after character");
   overrun_set_a: assert property (i_clk_en && i_rx.valid && dr_r && !rd_go |=> oe_r)
      else $error("overrun not flagged");
   parity_clear_a: assert property (lsr_read_s and !(i_rx.valid && par_bad) |=> !pe_r)
      else $error("parity flag survived status read");
   line_priority_a: assert property (i_clk_en && !freeze && pend[0] |=> iir_r[2:0] == 3'h6)
      else $error("line status not top priority");
   iid_freeze_a: assert property (iid_hold_s |=> $stable(iir_r))
      else $error("identification changed during read");
   iid_idle_a: assert property (i_clk_en && !freeze && pend == 4'h0 |=> iir_r == 8'h01)
      else $error("idle code wrong");
   ien_upper_a: assert property (i_clk_en && rd_act && addr == usp_pkg::OFF_IEN && !dab
                                 |=> o_data[7:4] == 4'h0)
      else $error("enable upper bits not zero");
   irq_inhibit_a: assert property (i_clk_en && ier_r[3:0] == 4'h0 |=> !o_irq_out)
      else $error("interrupt with all enables off");
   loop_bell_a: assert property (mcr_r[usp_pkg::MC_LOOP] |-> modem_input_state[6] == mcr_r[2] && modem_input_state[7] == mcr_r[3])
      else $error("loop status bits wrong");
   modem_out_a: assert property (i_clk_en |=> o_term_ready_n == !$past(mcr_r[0]))
      else $error("terminal ready not inverse of control");

endmodule : usp_core

// File: testbench/usp_modem_model.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Modem side: active-low levels, changed only on clock edges.
// ---------------------------------------------------------------
module usp_modem_model (
   input  wire logic              i_sys_clk,
   input  wire logic              i_ring,
   input  wire logic              i_carrier,
   output usp_pkg::usp_modem_in_t o_modem
);
   // Pins are registered so the design never sees a change mid-cycle; clear-to-send and set-ready stay off.
   initial o_modem = 4'hF;
   always @(posedge i_sys_clk) begin
      o_modem <= {1'b1, 1'b1, ~i_ring, ~i_carrier};
   end
endmodule : usp_modem_model

// File: testbench/usp_core_tb.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Bench for the status, interrupt and modem control block.
// ---------------------------------------------------------------
module usp_core_tb;
   logic                   clk = 1'b0;
   logic                   rstn = 1'b0;
   usp_pkg::usp_bus_t      bus = {1'b1, 1'b1, 1'b0, 1'b0, 3'h0, 1'b0, 1'b1, 1'b0, 1'b1};
   usp_pkg::usp_rx_t       rx = '0;
   usp_pkg::usp_modem_in_t mdm;
   logic [7:0]             din = 8'h00;
   logic [7:0]             dout;
   logic [7:0]             q;
   logic                   ring = 1'b0;
   logic                   carr = 1'b0;
   logic                   irq;
   logic                   oe;
   logic                   dtr_n, rts_n, o1_n, o2_n;
   logic                   tx_taken = 1'b0;
   logic                   tx_load;
   logic [7:0]             txd;
   logic [7:0]             lctl;
   logic [15:0]            div;
   logic [7:0]             loads = 8'h00;
   int                     failures = 0;
   int                     total_checks = 0;
   int                     cycles = 0;

   usp_core uut (.i_sys_clk(clk), .i_resetn(rstn), .i_clk_en(1'b1), .i_bus(bus), .i_data(din),
      .o_data(dout), .o_data_oe(oe), .i_rx(rx), .i_tx_taken(tx_taken), .i_tx_idle(1'b1), .o_tx_data(txd),
      .o_tx_load(tx_load), .o_divisor(div), .o_line_ctl(lctl), .i_modem(mdm), .o_irq_out(irq),
      .o_term_ready_n(dtr_n), .o_send_req_n(rts_n), .o_user_out1_n(o1_n), .o_user_out2_n(o2_n));
   usp_modem_model modem (.i_sys_clk(clk), .i_ring(ring), .i_carrier(carr), .o_modem(mdm));

   // A 100 ns clock, with a cycle ceiling so that a hang still ends in a verdict.
   always #50 clk = ~clk;
   always @(posedge clk) begin
      cycles++;
      if (tx_load === 1'b1) loads = loads + 8'h01;   // The load pulse lasts one cycle, so it is counted here.
      if (cycles == 5000) begin
         failures++;
         give_verdict();
      end
   end

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp) begin
         failures++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   // One register access; the strobe is held across one edge so the read answer is sampled while it stands.
   task automatic acc(input logic w, input logic [2:0] a, input logic [7:0] d);
      @(posedge clk) #10;
      bus.reg_sel = a;
      din = d;
      @(posedge clk) #10;
      if (w) bus.wr_strobe_n = 1'b0;
      else bus.rd_strobe_n = 1'b0;
      @(posedge clk) #10;
      q = dout;
      if (!w) chk({7'h00, oe}, 8'h01);
      bus.wr_strobe_n = 1'b1;
      bus.rd_strobe_n = 1'b1;
      @(posedge clk) #10;
   endtask : acc

   task automatic rxc(input logic [7:0] d, input logic p);
      @(posedge clk) #10;
      rx = {1'b1, d, p, 1'b0, 1'b0};
      @(posedge clk) #10;
      rx.valid = 1'b0;
      @(posedge clk) #10;
   endtask : rxc

   task automatic t_reset();
      acc(0, 3'h2, 8'h00); chk(q, 8'h01);
      acc(0, 3'h1, 8'h00); chk(q, 8'h00);
      acc(0, 3'h4, 8'h00); chk(q, 8'h00);
      chk({4'h0, dtr_n, rts_n, o1_n, o2_n}, 8'h0F);
      acc(1, 3'h1, 8'hFF); acc(0, 3'h1, 8'h00); chk(q, 8'h0F);
      acc(1, 3'h4, 8'h05);
      chk({4'h0, dtr_n, rts_n, o1_n, o2_n}, 8'h05);
   endtask : t_reset

   task automatic t_rx();
      acc(1, 3'h1, 8'h05);
      rxc(8'h55, 1'b0);
      acc(0, 3'h2, 8'h00); chk(q, 8'h04); chk({7'h00, irq}, 8'h01);
      rxc(8'h66, 1'b0);
      acc(0, 3'h2, 8'h00); chk(q, 8'h06);
      acc(0, 3'h5, 8'h00); chk(q, 8'h63);
      acc(0, 3'h5, 8'h00); chk(q, 8'h61);
      acc(0, 3'h0, 8'h00); chk(q, 8'h66);
      acc(0, 3'h5, 8'h00); chk(q, 8'h60);
      acc(0, 3'h2, 8'h00); chk(q, 8'h01);
      acc(1, 3'h3, 8'h08);
      rxc(8'h00, 1'b0);
      acc(0, 3'h5, 8'h00); chk(q, 8'h65);
      acc(0, 3'h5, 8'h00); chk(q, 8'h61);
      acc(1, 3'h5, 8'h00); acc(0, 3'h5, 8'h00); chk(q, 8'h60);
   endtask : t_rx

   task automatic t_modem();
      acc(1, 3'h1, 8'h08);
      acc(0, 3'h6, 8'h00);
      acc(1, 3'h4, 8'h1C);
      @(posedge clk) #10;   // The delta lands one edge after the loop write, the interrupt one edge later.
      chk({7'h00, irq}, 8'h01);
      acc(0, 3'h6, 8'h00); chk(q & 8'hFB, 8'hC8);
      acc(0, 3'h6, 8'h00); chk(q, 8'hC0);
      chk({7'h00, irq}, 8'h00);
      acc(1, 3'h4, 8'h00);
      acc(0, 3'h6, 8'h00); chk(q & 8'hF0, 8'h00);
      ring = 1'b1;
      repeat (3) @(posedge clk);
      #10 ring = 1'b0;
      acc(0, 3'h6, 8'h00); chk(q & 8'h44, 8'h04);
      acc(1, 3'h6, 8'h01); chk({7'h00, irq}, 8'h01);
      acc(0, 3'h6, 8'h00); chk({7'h00, irq}, 8'h00);
      acc(1, 3'h1, 8'h00);
      acc(1, 3'h6, 8'h01); chk({7'h00, irq}, 8'h00);
      acc(0, 3'h2, 8'h00); chk(q, 8'h01);
      acc(0, 3'h6, 8'h00); chk(q & 8'h01, 8'h01);
   endtask : t_modem

   // Transmit empty interrupt, divisor access, deselection and a held select latch.
   task automatic t_tx();
      acc(1, 3'h1, 8'h02);
      acc(1, 3'h0, 8'hA5);
      chk(txd, 8'hA5);
      acc(0, 3'h5, 8'h00);
      chk(q, 8'h40);
      @(posedge clk) #10 tx_taken = 1'b1;
      @(posedge clk) #10 tx_taken = 1'b0;
      acc(0, 3'h2, 8'h00);
      chk(q, 8'h02);
      chk({7'h00, irq}, 8'h00);
      acc(0, 3'h2, 8'h00);
      chk(q, 8'h01);
      @(posedge clk) #10 tx_taken = 1'b1;
      @(posedge clk) #10 tx_taken = 1'b0;
      acc(1, 3'h0, 8'h5A);
      acc(0, 3'h2, 8'h00);
      chk(q, 8'h01);
      acc(1, 3'h3, 8'h80);
      acc(1, 3'h0, 8'h34);
      acc(1, 3'h1, 8'h12);
      acc(0, 3'h0, 8'h00);
      chk(q, 8'h34);
      chk(div[15:8], 8'h12);
      chk(div[7:0], 8'h34);
      chk(lctl, 8'h80);
      acc(1, 3'h3, 8'h00);
      acc(0, 3'h1, 8'h00);
      chk(q, 8'h02);
      bus.chip_sel_lo_n = 1'b1;
      acc(1, 3'h1, 8'h0F);
      bus.chip_sel_lo_n = 1'b0;
      acc(0, 3'h1, 8'h00);
      chk(q, 8'h02);
      bus.sel_latch_n = 1'b1;
      acc(0, 3'h4, 8'h00);
      chk(q, 8'h02);
      bus.sel_latch_n = 1'b0;
      chk(loads, 8'h02);
   endtask : t_tx

   task automatic give_verdict();
      if (failures == 0 && total_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : give_verdict

   initial begin
      repeat (10) @(posedge clk);
      #10 rstn = 1'b1;
      t_reset();
      t_rx();
      t_modem();
      t_tx();
      give_verdict();
   end
endmodule : usp_core_tb
